// *** rtl/rsx_defs.svh ***
// constants for the rotate/subtract/xor/swap execute block
// assumes: included by the package and by the execute module
`ifndef RSX_DEFS_SVH
`define RSX_DEFS_SVH

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define RSX_DATA_W 8
`define RSX_FADDR_W 7
`define RSX_OP_W 4
`define RSX_RADDR_W 4
`define RSX_PRESC_W 8
`define RSX_WDT_W 8

// ------------------------------------------------------------
// register offsets on the plain register port
// ------------------------------------------------------------
`define RSX_REG_ACC 4'h0
`define RSX_REG_STATUS 4'h1
`define RSX_REG_DIR_A 4'h2
`define RSX_REG_DIR_B 4'h3
`define RSX_REG_DIR_C 4'h4
`define RSX_REG_WDT 4'h5
`define RSX_REG_PRESC 4'h6
`define RSX_REG_CORE 4'h7

// ------------------------------------------------------------
// status field positions
// ------------------------------------------------------------
`define RSX_ST_C 0
`define RSX_ST_DC 1
`define RSX_ST_Z 2
`define RSX_ST_PD 3
`define RSX_ST_TO 4

// ------------------------------------------------------------
// direction-load operand codes
// ------------------------------------------------------------
`define RSX_DIR_SEL_A 7'h05
`define RSX_DIR_SEL_B 7'h06
`define RSX_DIR_SEL_C 7'h07

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RSX_RST_ACC 8'h00
`define RSX_RST_DIR 8'hff
`define RSX_RST_TO 1'b1
`define RSX_RST_PD 1'b1

`endif

// *** rtl/rsx_pkg.sv ***
// types for the rotate/subtract/xor/swap execute block
// assumes: the defs header sits on the include path
package rsx_pkg;
`include "rsx_defs.svh"

	// ------------------------------------------------------------
	// operation codes from the decoder
	// ------------------------------------------------------------
	typedef enum logic [`RSX_OP_W-1:0] {
		OP_NONE = 4'h0,
		OP_ROTATE_RIGHT = 4'h1,
		OP_LITERAL_MINUS_ACC = 4'h2,
		OP_FILE_MINUS_ACC = 4'h3,
		OP_FILE_MINUS_ACC_BORROW = 4'h4,
		OP_NIBBLE_EXCHANGE = 4'h5,
		OP_DIRECTION_LOAD = 4'h6,
		OP_LITERAL_XOR = 4'h7,
		OP_FILE_XOR = 4'h8,
		OP_SLEEP = 4'h9
	} op_t;

	typedef enum logic {
		ST_RUN = 1'b0,
		ST_SLEEP = 1'b1
	} core_state_t;

	// ------------------------------------------------------------
	// whole state of the execute module
	// ------------------------------------------------------------
	typedef struct packed {
		logic [`RSX_DATA_W-1:0] acc;
		logic carry;
		logic half_carry;
		logic zero;
		logic timeout_flag;
		logic powerdown_flag;
		logic [`RSX_DATA_W-1:0] port_a_direction;
		logic [`RSX_DATA_W-1:0] port_b_direction;
		logic [`RSX_DATA_W-1:0] port_c_direction;
		logic [`RSX_PRESC_W-1:0] presc;
		logic [`RSX_WDT_W-1:0] watchdog_counter;
		core_state_t core_state;
		logic file_we;
		logic [`RSX_FADDR_W-1:0] file_addr;
		logic [`RSX_DATA_W-1:0] file_wdata;
		logic [`RSX_DATA_W-1:0] rdata;
		logic wake_meta;
		logic wake_sync;
	} exec_state_t;

endpackage : rsx_pkg

// *** rtl/flag_subtract.sv ***
// subtractor giving difference, carry (no borrow) and half carry
// assumes: purely combinational, used by the execute module
`timescale 1ns/1ps
module flag_subtract #(
	parameter int WIDTH = 8
) (
	input wire logic [WIDTH-1:0] i_minuend, // value subtracted from
	input wire logic [WIDTH-1:0] i_subtrahend, // value subtracted
	input wire logic i_borrow, // extra one subtracted when high
	output logic [WIDTH-1:0] o_diff, // two's complement difference
	output logic o_carry, // high when no borrow out of the top bit
	output logic o_half_carry // high when no borrow out of the low half
);
	localparam int HALF = WIDTH / 2;

	logic [WIDTH:0] full;
	logic [HALF:0] low;

	initial begin
		if (WIDTH < 2 || (WIDTH % 2) != 0) begin
			$error("flag_subtract: WIDTH must be even and at least 2");
		end
	end

	// ------------------------------------------------------------
	// subtraction
	// ------------------------------------------------------------
	always_comb begin
		full = {1'b0, i_minuend} - {1'b0, i_subtrahend} - {{WIDTH{1'b0}}, i_borrow};
		low = {1'b0, i_minuend[HALF-1:0]} - {1'b0, i_subtrahend[HALF-1:0]}
			- {{HALF{1'b0}}, i_borrow};
		o_diff = full[WIDTH-1:0];
		o_carry = ~full[WIDTH];
		o_half_carry = ~low[HALF];
	end

endmodule : flag_subtract

// *** rtl/rotate_subtract_xor_swap_execute.sv ***
// execute stage for rotate, subtract, swap, xor, direction load and sleep
// assumes: decoder presents one operation per cycle with the addressed file
// register value already read; file write-back is taken one cycle later
//
// Summary of operation
// - rotate right moves old carry into bit 7, bit 0 into carry only
// - destination bit 0 writes accumulator, 1 writes addressed file register
// - literal minus accumulator result goes into the accumulator
// - subtracts set carry and half carry when no borrow, else clear
// - file minus accumulator result goes to the selected destination
// - subtract with borrow also takes the inverted carry away
// - nibble exchange swaps halves of file value, flags untouched
// - direction load copies accumulator to port a, b or c by operand 5,6,7
// - literal xor writes accumulator, changes zero flag only
// - file xor writes selected destination, changes zero flag only
// - sleep clears power-down flag and sets timeout flag
// - sleep clears the watchdog counter and its prescaler
// - after sleep the core halts with oscillator stopped, no operations until a synchronised wake request
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "rsx_defs.svh"
module rotate_subtract_xor_swap_execute
	import rsx_pkg::*;
(
	input wire logic i_clk, // core instruction clock
	input wire logic i_rst, // synchronous reset, active high
	input wire logic i_op_valid, // an operation is presented this cycle
	input wire logic [`RSX_OP_W-1:0] i_op_code, // operation code
	input wire logic [`RSX_FADDR_W-1:0] i_file_addr, // file address or direction operand
	input wire logic i_dest, // destination bit
	input wire logic [`RSX_DATA_W-1:0] i_literal, // immediate value
	input wire logic [`RSX_DATA_W-1:0] i_file_data, // value of the addressed file register
	input wire logic i_wake, // wake request from outside, asynchronous
	input wire logic [`RSX_RADDR_W-1:0] i_reg_addr, // register port address
	input wire logic [`RSX_DATA_W-1:0] i_reg_wdata, // register port write data
	input wire logic i_reg_wr, // register write strobe
	input wire logic i_reg_rd, // register read strobe
	output logic [`RSX_DATA_W-1:0] o_reg_rdata, // read data, cycle after the strobe
	output logic o_op_ready, // operations are accepted
	output logic o_file_we, // file write-back pulse
	output logic [`RSX_FADDR_W-1:0] o_file_addr, // file write-back address
	output logic [`RSX_DATA_W-1:0] o_file_wdata, // file write-back data
	output logic [`RSX_DATA_W-1:0] o_acc, // accumulator
	output logic o_carry, // carry flag
	output logic o_half_carry_flag, // half carry flag
	output logic o_zero, // zero flag
	output logic o_timeout_flag, // timeout status flag
	output logic o_powerdown_flag, // power-down status flag
	output logic [`RSX_DATA_W-1:0] o_port_a_direction, // port a direction register
	output logic [`RSX_DATA_W-1:0] o_port_b_direction, // port b direction register
	output logic [`RSX_DATA_W-1:0] o_port_c_direction, // port c direction register
	output logic [`RSX_WDT_W-1:0] o_watchdog_counter, // watchdog count
	output logic o_osc_run // main oscillator enable, low while halted
);

	exec_state_t s_reg;
	exec_state_t s_next;

	op_t op;
	logic take;
	logic [`RSX_DATA_W-1:0] sub_minuend;
	logic sub_borrow;
	logic [`RSX_DATA_W-1:0] sub_diff;
	logic sub_carry;
	logic sub_half;
	logic [`RSX_DATA_W-1:0] result;
	logic write_result;
	logic upd_carry;
	logic new_carry;
	logic upd_half;
	logic upd_zero;
	logic [`RSX_DATA_W-1:0] status_view;

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	// the nibble halves, the read view and the operand codes are laid out for these sizes
	initial begin
		if (`RSX_DATA_W != 8) begin
			$error("execute: data width must be 8");
		end
		if (`RSX_WDT_W != `RSX_DATA_W || `RSX_PRESC_W != `RSX_DATA_W) begin
			$error("execute: watchdog and prescaler must match the data width");
		end
		if (`RSX_FADDR_W < 3) begin
			$error("execute: file address too narrow for the direction operands");
		end
		if (`RSX_RADDR_W < 3) begin
			$error("execute: register address too narrow for eight offsets");
		end
		if (`RSX_ST_TO >= `RSX_DATA_W) begin
			$error("execute: status fields do not fit the data width");
		end
	end

	// ------------------------------------------------------------
	// shared subtractor
	// ------------------------------------------------------------
	always_comb begin
		op = op_t'(i_op_code);
		sub_minuend = (op == OP_LITERAL_MINUS_ACC) ? i_literal : i_file_data;
		sub_borrow = (op == OP_FILE_MINUS_ACC_BORROW) ? ~s_reg.carry : 1'b0;
	end

	flag_subtract #(
		.WIDTH(`RSX_DATA_W)
	) u_sub (
		.i_minuend(sub_minuend),
		.i_subtrahend(s_reg.acc),
		.i_borrow(sub_borrow),
		.o_diff(sub_diff),
		.o_carry(sub_carry),
		.o_half_carry(sub_half)
	);

	// ------------------------------------------------------------
	// operation result and flag selection
	// ------------------------------------------------------------
	always_comb begin
		result = s_reg.acc;
		write_result = 1'b0;
		upd_carry = 1'b0;
		new_carry = s_reg.carry;
		upd_half = 1'b0;
		upd_zero = 1'b0;
		unique case (op)
			OP_ROTATE_RIGHT: begin
				result = {s_reg.carry, i_file_data[`RSX_DATA_W-1:1]};
				new_carry = i_file_data[0];
				upd_carry = 1'b1;
				write_result = 1'b1;
			end
			OP_LITERAL_MINUS_ACC, OP_FILE_MINUS_ACC, OP_FILE_MINUS_ACC_BORROW: begin
				result = sub_diff;
				new_carry = sub_carry;
				upd_carry = 1'b1;
				upd_half = 1'b1;
				upd_zero = 1'b1;
				write_result = 1'b1;
			end
			OP_NIBBLE_EXCHANGE: begin
				result = {i_file_data[3:0], i_file_data[7:4]};
				write_result = 1'b1;
			end
			OP_LITERAL_XOR: begin
				result = s_reg.acc ^ i_literal;
				upd_zero = 1'b1;
				write_result = 1'b1;
			end
			OP_FILE_XOR: begin
				result = s_reg.acc ^ i_file_data;
				upd_zero = 1'b1;
				write_result = 1'b1;
			end
			default: begin
				result = s_reg.acc;
			end
		endcase
	end

	// ------------------------------------------------------------
	// register read view
	// ------------------------------------------------------------
	always_comb begin
		status_view = '0;
		status_view[`RSX_ST_C] = s_reg.carry;
		status_view[`RSX_ST_DC] = s_reg.half_carry;
		status_view[`RSX_ST_Z] = s_reg.zero;
		status_view[`RSX_ST_PD] = s_reg.powerdown_flag;
		status_view[`RSX_ST_TO] = s_reg.timeout_flag;
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		take = i_op_valid && (s_reg.core_state == ST_RUN);

		// wake request synchroniser
		s_next.wake_meta = i_wake;
		s_next.wake_sync = s_reg.wake_meta;

		s_next.file_we = 1'b0;

		// read data only in the cycle after the strobe
		s_next.rdata = '0;
		if (i_reg_rd) begin
			case (i_reg_addr)
				`RSX_REG_ACC: s_next.rdata = s_reg.acc;
				`RSX_REG_STATUS: s_next.rdata = status_view;
				`RSX_REG_DIR_A: s_next.rdata = s_reg.port_a_direction;
				`RSX_REG_DIR_B: s_next.rdata = s_reg.port_b_direction;
				`RSX_REG_DIR_C: s_next.rdata = s_reg.port_c_direction;
				`RSX_REG_WDT: s_next.rdata = s_reg.watchdog_counter;
				`RSX_REG_PRESC: s_next.rdata = s_reg.presc;
				`RSX_REG_CORE: s_next.rdata = {7'h00, s_reg.core_state == ST_SLEEP};
				default: s_next.rdata = '0;
			endcase
		end

		// software writes; an operation in the same cycle overrides them
		if (i_reg_wr) begin
			case (i_reg_addr)
				`RSX_REG_ACC: s_next.acc = i_reg_wdata;
				`RSX_REG_STATUS: begin
					s_next.carry = i_reg_wdata[`RSX_ST_C];
					s_next.half_carry = i_reg_wdata[`RSX_ST_DC];
					s_next.zero = i_reg_wdata[`RSX_ST_Z];
				end
				`RSX_REG_DIR_A: s_next.port_a_direction = i_reg_wdata;
				`RSX_REG_DIR_B: s_next.port_b_direction = i_reg_wdata;
				`RSX_REG_DIR_C: s_next.port_c_direction = i_reg_wdata;
				default: s_next.acc = s_next.acc;
			endcase
		end

		// watchdog runs only while the oscillator runs
		if (s_reg.core_state == ST_RUN) begin
			s_next.presc = s_reg.presc + 1'b1;
			if (&s_reg.presc) begin
				s_next.watchdog_counter = s_reg.watchdog_counter + 1'b1;
			end
		end

		if (s_reg.core_state == ST_SLEEP && s_reg.wake_sync) begin
			s_next.core_state = ST_RUN;
		end

		// all results and flags commit on the edge that ends the cycle
		if (take) begin
			if (write_result) begin
				if (i_dest && op != OP_LITERAL_MINUS_ACC && op != OP_LITERAL_XOR) begin
					s_next.file_we = 1'b1;
					s_next.file_addr = i_file_addr;
					s_next.file_wdata = result;
				end else begin
					s_next.acc = result;
				end
			end
			if (upd_carry) begin
				s_next.carry = new_carry;
			end
			if (upd_half) begin
				s_next.half_carry = sub_half;
			end
			if (upd_zero) begin
				s_next.zero = (result == '0);
			end
			if (op == OP_DIRECTION_LOAD) begin
				case (i_file_addr)
					`RSX_DIR_SEL_A: s_next.port_a_direction = s_reg.acc;
					`RSX_DIR_SEL_B: s_next.port_b_direction = s_reg.acc;
					`RSX_DIR_SEL_C: s_next.port_c_direction = s_reg.acc;
					default: s_next.port_a_direction = s_next.port_a_direction;
				endcase
			end
			if (op == OP_SLEEP) begin
				s_next.powerdown_flag = 1'b0;
				s_next.timeout_flag = 1'b1;
				s_next.watchdog_counter = '0;
				s_next.presc = '0;
				s_next.core_state = ST_SLEEP;
			end
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s_reg <= '0;
			s_reg.acc <= `RSX_RST_ACC;
			s_reg.timeout_flag <= `RSX_RST_TO;
			s_reg.powerdown_flag <= `RSX_RST_PD;
			s_reg.port_a_direction <= `RSX_RST_DIR;
			s_reg.port_b_direction <= `RSX_RST_DIR;
			s_reg.port_c_direction <= `RSX_RST_DIR;
			s_reg.core_state <= ST_RUN;
		end else begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_reg_rdata = s_reg.rdata;
	assign o_op_ready = (s_reg.core_state == ST_RUN);
	assign o_osc_run = (s_reg.core_state == ST_RUN);
	assign o_file_we = s_reg.file_we;
	assign o_file_addr = s_reg.file_addr;
	assign o_file_wdata = s_reg.file_wdata;
	assign o_acc = s_reg.acc;
	assign o_carry = s_reg.carry;
	assign o_half_carry_flag = s_reg.half_carry;
	assign o_zero = s_reg.zero;
	assign o_timeout_flag = s_reg.timeout_flag;
	assign o_powerdown_flag = s_reg.powerdown_flag;
	assign o_port_a_direction = s_reg.port_a_direction;
	assign o_port_b_direction = s_reg.port_b_direction;
	assign o_port_c_direction = s_reg.port_c_direction;
	assign o_watchdog_counter = s_reg.watchdog_counter;

endmodule : rotate_subtract_xor_swap_execute

// *** sim/rsx_file_model.sv ***
// register file behind the execute block, as the decoder presents it
// assumes: combinational read, write-back is a one-cycle pulse
`timescale 1ns/1ps
module rsx_file_model (
	input wire logic i_clk, // clock
	input wire logic [6:0] i_addr, // read address
	input wire logic i_we, // write-back pulse
	input wire logic [6:0] i_waddr, // write-back address
	input wire logic [7:0] i_wdata, // write-back data
	output logic [7:0] o_data // addressed value
);
	logic [7:0] mem [128];
	initial begin
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'(i * 37 + 5);
		end
	end
	assign o_data = mem[i_addr];
	always @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end
endmodule : rsx_file_model

// *** sim/rotate_subtract_xor_swap_execute_sva.sv ***
// assertions on the operation port of the execute block
// assumes: bound into the execute module, one clock, sync reset
`timescale 1ns/1ps
`include "rsx_defs.svh"
module rsx_checker
	import rsx_pkg::*;
(
	input wire logic i_clk, // clock
	input wire logic i_rst, // reset
	input wire logic i_op_valid, // op valid
	input wire logic [`RSX_OP_W-1:0] i_op_code, // op code
	input wire logic [`RSX_FADDR_W-1:0] i_file_addr, // operand
	input wire logic i_dest, // destination
	input wire logic [`RSX_DATA_W-1:0] i_literal, // immediate
	input wire logic [`RSX_DATA_W-1:0] i_file_data, // file value
	input wire logic o_op_ready, // ready
	input wire logic o_osc_run, // oscillator
	input wire logic o_file_we, // write-back
	input wire logic [`RSX_DATA_W-1:0] o_file_wdata, // write-back data
	input wire logic [`RSX_DATA_W-1:0] o_acc, // accumulator
	input wire logic o_carry, // carry
	input wire logic o_zero, // zero
	input wire logic o_timeout_flag, // timeout
	input wire logic o_powerdown_flag, // power-down
	input wire logic [`RSX_DATA_W-1:0] o_port_a_direction, // port a direction
	input wire logic [`RSX_WDT_W-1:0] o_watchdog_counter // watchdog
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence taken(op_t c);
		i_op_valid && o_op_ready && i_op_code == c;
	endsequence
	sequence taken_d(op_t c, logic d);
		taken(c) ##0 i_dest == d;
	endsequence
	sleep_flags_a: assert property (taken(OP_SLEEP) |=> !o_powerdown_flag && o_timeout_flag)
		else $error("sleep flags wrong");
	sleep_watchdog_a: assert property (taken(OP_SLEEP) |=> o_watchdog_counter == 8'h00)
		else $error("watchdog not cleared");
	sleep_halt_a: assert property (taken(OP_SLEEP) |=> (!o_op_ready && !o_osc_run) [*2])
		else $error("core still running");
	rotate_back_a:
		assert property (taken_d(OP_ROTATE_RIGHT, 1'b1) |=> o_file_we && $stable(o_zero)
			&& o_file_wdata == ({$past(o_carry), 7'h00} | ($past(i_file_data) >> 1))
			&& {7'h00, o_carry} == ($past(i_file_data) & 8'h01))
		else $error("rotate result wrong");
	file_xor_a:
		assert property (taken_d(OP_FILE_XOR, 1'b0) |=> !o_file_we
			&& o_acc == ($past(o_acc) ^ $past(i_file_data)) && $stable(o_carry))
		else $error("file xor wrong");
	swap_acc_a:
		assert property (taken_d(OP_NIBBLE_EXCHANGE, 1'b0) |=> $stable(o_carry) && $stable(o_zero)
			&& o_acc == (($past(i_file_data) << 4) | ($past(i_file_data) >> 4)))
		else $error("nibble exchange wrong");
	lit_sub_a:
		assert property (taken(OP_LITERAL_MINUS_ACC) |=> o_zero == (o_acc == 8'h00)
			&& o_acc == 8'($past(i_literal) - $past(o_acc)) && o_carry == ($past(o_acc) <= $past(i_literal)))
		else $error("literal subtract wrong");
	lit_xor_a:
		assert property (taken(OP_LITERAL_XOR) |=> $stable(o_carry) && o_zero == (o_acc == 8'h00)
			&& o_acc == ($past(o_acc) ^ $past(i_literal)))
		else $error("literal xor wrong");
	dir_load_a:
		assert property (taken(OP_DIRECTION_LOAD) ##0 i_file_addr == 7'h05
			|=> o_port_a_direction == $past(o_acc))
		else $error("direction load wrong");
endmodule : rsx_checker
bind rotate_subtract_xor_swap_execute rsx_checker u_checker (.*);

// *** sim/rotate_subtract_xor_swap_execute_tb.sv ***
// self-checking bench: random and directed operations against an integer model
// assumes: file register model beside the design, checker bound in
`timescale 1ns/1ps
`include "rsx_defs.svh"
module rotate_subtract_xor_swap_execute_tb
	import rsx_pkg::*;
;
	logic i_clk = 0, i_rst = 1, i_op_valid = 0, i_dest = 0, i_wake = 0, i_reg_wr = 0, i_reg_rd = 0;
	logic [3:0] i_op_code = 0, i_reg_addr = 0;
	logic [6:0] i_file_addr = 0, o_file_addr;
	logic [7:0] i_literal = 0, i_reg_wdata = 0, i_file_data, o_reg_rdata, o_file_wdata, o_acc;
	logic [7:0] o_port_a_direction, o_port_b_direction, o_port_c_direction, o_watchdog_counter;
	logic o_op_ready, o_file_we, o_carry, o_half_carry_flag, o_zero;
	logic o_timeout_flag, o_powerdown_flag, o_osc_run;
	int num_errors = 0, num_checks = 0, acc = 0, c = 0, dc = 0, z = 0, asleep = 0;
	int dir[3] = '{255, 255, 255};
	int f[128];
	always #5 i_clk = ~i_clk;
	rotate_subtract_xor_swap_execute dut (.*);
	rsx_file_model u_file (.i_clk(i_clk), .i_addr(i_file_addr), .i_we(o_file_we),
		.i_waddr(o_file_addr), .i_wdata(o_file_wdata), .o_data(i_file_data));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic results();
		if (num_errors == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_clk);
		i_reg_rd <= 1'b0;
		#1 d = o_reg_rdata;
	endtask : reg_rd
	function automatic int sub(int m, int s, int bo);
		dc = ((m & 15) - (s & 15) - bo) >= 0;
		c = (m - s - bo) >= 0;
		sub = (m - s - bo) & 255;
		z = sub == 0;
	endfunction : sub
	// one operation, then compare write-back, accumulator, carry, half carry, zero and directions against the model
	task automatic op(input int code, input int a, input int d, input int k);
		int r;
		int fa;
		int b;
		@(posedge i_clk);
		i_op_valid <= 1'b1;
		i_op_code <= 4'(code);
		i_file_addr <= 7'(a);
		i_dest <= 1'(d);
		i_literal <= 8'(k);
		#1 chk(8'(o_op_ready), 8'(asleep == 0));
		@(posedge i_clk);
		i_op_valid <= 1'b0;
		fa = f[a];
		r = -1;
		b = 1 - c;
		if (asleep == 0) case (code)
			1: begin r = (c << 7) | (fa >> 1); c = fa & 1; end
			2: begin r = sub(k, acc, 0); d = 0; end
			3: r = sub(fa, acc, 0);
			4: r = sub(fa, acc, b);
			5: r = ((fa & 15) << 4) | (fa >> 4);
			6: if (a >= 5 && a <= 7) dir[a - 5] = acc;
			7: begin r = acc ^ k; z = r == 0; d = 0; end
			8: begin r = fa ^ acc; z = r == 0; end
			9: asleep = 1;
			default: r = -1;
		endcase
		if (r >= 0 && d == 1) f[a] = r;
		else if (r >= 0) acc = r;
		#1;
		chk(8'(o_file_we), 8'(r >= 0 && d == 1));
		if (o_file_we === 1'b1) chk({o_file_addr, 1'b0}, 8'(a * 2));
		if (o_file_we === 1'b1) chk(o_file_wdata, 8'(r));
		chk(o_acc, 8'(acc));
		chk({5'h00, o_zero, o_half_carry_flag, o_carry}, 8'(z * 4 + dc * 2 + c));
		chk(o_port_a_direction, 8'(dir[0]));
		chk(o_port_b_direction, 8'(dir[1]));
		chk(o_port_c_direction, 8'(dir[2]));
	endtask : op
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		int v;
		logic [7:0] rd;
		for (int i = 0; i < 128; i++) f[i] = (i * 37 + 5) & 255;
		v = $urandom(37);
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		reg_rd(4'h1, rd);
		chk(rd, 8'h18);
		reg_rd(4'h2, rd);
		chk(rd, 8'hff);
		reg_rd(4'h9, rd);
		chk(rd, 8'h00);
		reg_wr(4'h0, 8'h3c);
		reg_wr(4'h1, 8'h01);
		acc = 60;
		c = 1;
		reg_rd(4'h0, rd);
		chk(rd, 8'h3c);
		op(2, 0, 1, 60);
		op(7, 0, 0, 129);
		op(2, 0, 0, 16);
		op(4, 9, 1, 0);
		for (int a = 4; a <= 8; a++) op(6, a, 0, 0);
		op(0, 1, 1, 0);
		op(12, 2, 1, 0);
		repeat (300) op($urandom_range(1, 8), $urandom_range(0, 127), $urandom_range(0, 1),
			$urandom_range(0, 255));
		op(9, 0, 0, 0);
		chk(8'({o_timeout_flag, o_powerdown_flag, o_op_ready, o_osc_run}), 8'h08);
		chk(o_watchdog_counter, 8'h00);
		reg_rd(4'h6, rd);
		chk(rd, 8'h00);
		reg_rd(4'h7, rd);
		chk(rd, 8'h01);
		op(7, 0, 0, 255);
		@(posedge i_clk);
		i_wake <= 1'b1;
		repeat (3) @(posedge i_clk);
		i_wake <= 1'b0;
		#1 chk(8'(o_op_ready), 8'h01);
		asleep = 0;
		op(8, 3, 1, 0);
		reg_rd(4'h1, rd);
		chk(rd, 8'(16 + z * 4 + dc * 2 + c));
		results();
	end
	initial begin
		#50000;
		num_errors++;
		results();
	end
endmodule : rotate_subtract_xor_swap_execute_tb
